//--- hdl/current_ramp.v
`timescale 1ns/1ps
`default_nettype none
`include "motor_tuning_defines.vh"

// Moves a current level toward a target, one unit of 0.1 % per step.
// A rate of N ms per 100 % is N ms per 1000 units, so one step every
// N * (cycles per ms) / 1000 cycles; zero rate jumps at once.
module current_ramp #(
    parameter CYCLES_PER_MS = `CYCLES_PER_MS
)(
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Control
    input  wire [15:0] target,
    input  wire [15:0] rate_up,
    input  wire [15:0] rate_down,
    // Result
    output reg  [15:0] level
);

    reg  [31:0] tick_cnt;
    wire        going_up   = target > level;
    wire [15:0] rate       = going_up ? rate_up : rate_down;
    wire [31:0] step_len   = (rate * CYCLES_PER_MS) / 1000;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            level    <= 16'h0000;
            tick_cnt <= 32'h0000_0000;
        end
        else if (target == level)
        begin
            tick_cnt <= 32'h0000_0000;
        end
        else if (rate == 16'h0000)
        begin
            level    <= target;
            tick_cnt <= 32'h0000_0000;
        end
        else if (tick_cnt + 32'h1 >= step_len)
        begin
            tick_cnt <= 32'h0000_0000;
            level    <= going_up ? level + 16'h0001 : level - 16'h0001;
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

endmodule // current_ramp

`default_nettype wire

//--- hdl/motor_current_control_tuning.v
// Contract
// - Resonance frequency setting spans 100 to 2000 Hz, reset 1000.
// - Resonance frequency writes below 100 Hz store exactly 100.
// - Signed resonance gain held between -500 and 500, reset 0.
// - Cutback drops to stop current at standstill, restores when moving.
// - Cutback enable: 0 off, 1 on, default 1; off keeps operating current.
// - Cutback waits 0 to 1000 ms after stop, default 100.
// - Mode code 0 follows input, 1 closed-loop, 2 servo emulation.
// - Deferred mode: input on selects servo emulation, off closed-loop.
// - Servo emulation ratio 0 to 1000 in 0.1 percent, default 1000.
// - Ratio zero forces closed-loop current mode.
// - Ratio and servo gains apply only in servo emulation mode.
// - Position loop gain 1 to 50, default 10.
// - Speed loop gain 10 to 200, default 180.
// - Speed integral time 100 to 2000 in 0.1 ms, default 1000.
// - Operating current rises at most at programmed up rate.
// - Operating current falls at most at programmed down rate.
// - Ramps govern operating current changes, not standstill cutback.
// - Deviation acceleration suppression gain 0 to 500, default 45.
`timescale 1ns/1ps
`default_nettype none
`include "motor_tuning_defines.vh"

module motor_current_control_tuning (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Register port
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // Motion state and mode pin
    input  wire        motion_active,
    input  wire        current_mode_select_input,
    // Current control outputs
    output reg  [15:0] current_cmd,
    output reg         servo_emulation_mode,
    output reg         closed_loop_current_mode,
    output reg  [15:0] servo_current,
    // Filter and loop settings toward the control loop
    output reg  [15:0] res_freq,
    output reg  [15:0] res_gain,
    output reg  [15:0] pos_gain,
    output reg  [15:0] spd_gain,
    output reg  [15:0] spd_integ,
    output reg  [15:0] dev_acc_gain
);

    // ----------------------------------------
    // Clamp helpers
    // ----------------------------------------
    function [15:0] clamp_u;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo)
                clamp_u = lo;
            else if (v > hi)
                clamp_u = hi;
            else
                clamp_u = v;
        end
    endfunction

    function [15:0] clamp_s;
        input [15:0] v;
        begin
            if ($signed(v) < $signed(`RES_GAIN_MIN))
                clamp_s = `RES_GAIN_MIN;
            else if ($signed(v) > $signed(`RES_GAIN_MAX))
                clamp_s = `RES_GAIN_MAX;
            else
                clamp_s = v;
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Mode output moves three cycles after the pin
    reg [1:0] motion_sync;
    reg [1:0] mode_pin_sync;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            motion_sync   <= 2'b00;
            mode_pin_sync <= 2'b00;
        end
        else
        begin
            motion_sync   <= {motion_sync[0], motion_active};
            mode_pin_sync <= {mode_pin_sync[0], current_mode_select_input};
        end
    end

    wire moving   = motion_sync[1];
    wire mode_pin = mode_pin_sync[1];

    // ----------------------------------------
    // Settings
    // ----------------------------------------
    reg        cutback_en;
    reg [15:0] cutback_delay;
    reg [1:0]  cur_mode;
    reg [15:0] sve_ratio;
    reg [15:0] ramp_up;
    reg [15:0] ramp_down;
    reg [15:0] op_current;
    reg [15:0] stop_current;
    reg [15:0] pos_gain_set;
    reg [15:0] spd_gain_set;
    reg [15:0] spd_integ_set;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            res_freq      <= `RES_FREQ_RST;
            res_gain      <= `RES_GAIN_RST;
            cutback_en    <= `CUTBACK_EN_RST;
            cutback_delay <= `CUTBACK_DELAY_RST;
            cur_mode      <= `CUR_MODE_RST;
            sve_ratio     <= `SVE_RATIO_RST;
            pos_gain_set  <= `POS_GAIN_RST;
            spd_gain_set  <= `SPD_GAIN_RST;
            spd_integ_set <= `SPD_INTEG_RST;
            ramp_up       <= `RAMP_RST;
            ramp_down     <= `RAMP_RST;
            dev_acc_gain  <= `DEV_ACC_RST;
            op_current    <= `OP_CURRENT_RST;
            stop_current  <= `STOP_CURRENT_RST;
        end
        else if (wr)
        begin
            // Out-of-range writes saturate rather than being refused; cutback enable keeps only bit 0
            if (addr == `ADDR_RES_FREQ)
                res_freq <= clamp_u(wdata, `RES_FREQ_MIN, `RES_FREQ_MAX);
            else if (addr == `ADDR_RES_GAIN)
                res_gain <= clamp_s(wdata);
            else if (addr == `ADDR_CUTBACK_EN)
                cutback_en <= wdata[0];
            else if (addr == `ADDR_CUTBACK_DELAY)
                cutback_delay <= clamp_u(wdata, 16'h0000, `CUTBACK_DELAY_MAX);
            else if (addr == `ADDR_CUR_MODE)
                cur_mode <= (wdata > 16'h0002) ? `CUR_MODE_SERVO : wdata[1:0];
            else if (addr == `ADDR_SVE_RATIO)
                sve_ratio <= clamp_u(wdata, 16'h0000, `SVE_RATIO_MAX);
            else if (addr == `ADDR_POS_GAIN)
                pos_gain_set <= clamp_u(wdata, `POS_GAIN_MIN, `POS_GAIN_MAX);
            else if (addr == `ADDR_SPD_GAIN)
                spd_gain_set <= clamp_u(wdata, `SPD_GAIN_MIN, `SPD_GAIN_MAX);
            else if (addr == `ADDR_SPD_INTEG)
                spd_integ_set <= clamp_u(wdata, `SPD_INTEG_MIN, `SPD_INTEG_MAX);
            else if (addr == `ADDR_RAMP_UP)
                ramp_up <= clamp_u(wdata, 16'h0000, `RAMP_MAX);
            else if (addr == `ADDR_RAMP_DOWN)
                ramp_down <= clamp_u(wdata, 16'h0000, `RAMP_MAX);
            else if (addr == `ADDR_DEV_ACC_GAIN)
                dev_acc_gain <= clamp_u(wdata, 16'h0000, `DEV_ACC_MAX);
            else if (addr == `ADDR_OP_CURRENT)
                op_current <= clamp_u(wdata, 16'h0000, `CURRENT_FULL);
            else if (addr == `ADDR_STOP_CURRENT)
                stop_current <= clamp_u(wdata, 16'h0000, `CURRENT_FULL);
        end
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // A zero ratio overrides every mode code
    reg next_servo;

    always @*
    begin
        if (sve_ratio == 16'h0000)
            next_servo = 1'b0;
        else if (cur_mode == `CUR_MODE_CLOSED)
            next_servo = 1'b0;
        else if (cur_mode == `CUR_MODE_SERVO)
            next_servo = 1'b1;
        else
            next_servo = mode_pin;
    end

    // ----------------------------------------
    // Operating current ramp
    // ----------------------------------------
    wire [15:0] ramped_current;

    // Ramp sees only operating-current changes; cutback bypasses it
    current_ramp #(
        .CYCLES_PER_MS (`CYCLES_PER_MS)
    ) u_ramp (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .target    (op_current),
        .rate_up   (ramp_up),
        .rate_down (ramp_down),
        .level     (ramped_current)
    );

    // ----------------------------------------
    // Standstill cutback
    // ----------------------------------------
    reg [15:0] ms_count;
    reg [16:0] sub_count;
    reg        cut_active;

    // Whole ms only; delay 0 cuts on the cycle after stop
    // Count freezes once the cut holds, so it cannot wrap
    wire ms_tick = (sub_count == `CYCLES_PER_MS - 1);

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_count  <= 17'h00000;
            ms_count   <= 16'h0000;
            cut_active <= 1'b0;
        end
        else if (moving || !cutback_en)
        begin
            sub_count  <= 17'h00000;
            ms_count   <= 16'h0000;
            cut_active <= 1'b0;
        end
        else if (ms_count >= cutback_delay)
        begin
            cut_active <= 1'b1;
        end
        else
        begin
            sub_count <= ms_tick ? 17'h00000 : sub_count + 17'h00001;
            if (ms_tick)
                ms_count <= ms_count + 16'h0001;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    wire [15:0] applied = cut_active ? stop_current : ramped_current;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            current_cmd              <= 16'h0000;
            servo_emulation_mode     <= 1'b0;
            closed_loop_current_mode <= 1'b1;
        end
        else
        begin
            current_cmd              <= applied;
            servo_emulation_mode     <= next_servo;
            closed_loop_current_mode <= !next_servo;
        end
    end

    // ----------------------------------------
    // Servo emulation terms
    // ----------------------------------------
    // Product fits 20 bits; quotient never exceeds full current
    wire [31:0] servo_mul  = applied * sve_ratio;
    wire [31:0] servo_quot = servo_mul / 32'd1000;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            servo_current <= 16'h0000;
            pos_gain      <= 16'h0000;
            spd_gain      <= 16'h0000;
            spd_integ     <= 16'h0000;
        end
        else
        begin
            // Servo terms read zero outside servo emulation
            servo_current <= next_servo ? servo_quot[15:0] : 16'h0000;
            pos_gain      <= next_servo ? pos_gain_set  : 16'h0000;
            spd_gain      <= next_servo ? spd_gain_set  : 16'h0000;
            spd_integ     <= next_servo ? spd_integ_set : 16'h0000;
        end
    end

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    // Bits: cut active, servo mode, motion seen
    wire [15:0] status_word = {13'h0000, cut_active, servo_emulation_mode, moving};

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Idle cycles and unmapped offsets read as zero

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata <= 16'h0000;
        else if (!rd)
            rdata <= 16'h0000;
        else if (addr == `ADDR_RES_FREQ)
            rdata <= res_freq;
        else if (addr == `ADDR_RES_GAIN)
            rdata <= res_gain;
        else if (addr == `ADDR_CUTBACK_EN)
            rdata <= {15'h0000, cutback_en};
        else if (addr == `ADDR_CUTBACK_DELAY)
            rdata <= cutback_delay;
        else if (addr == `ADDR_CUR_MODE)
            rdata <= {14'h0000, cur_mode};
        else if (addr == `ADDR_SVE_RATIO)
            rdata <= sve_ratio;
        else if (addr == `ADDR_POS_GAIN)
            rdata <= pos_gain_set;
        else if (addr == `ADDR_SPD_GAIN)
            rdata <= spd_gain_set;
        else if (addr == `ADDR_SPD_INTEG)
            rdata <= spd_integ_set;
        else if (addr == `ADDR_RAMP_UP)
            rdata <= ramp_up;
        else if (addr == `ADDR_RAMP_DOWN)
            rdata <= ramp_down;
        else if (addr == `ADDR_DEV_ACC_GAIN)
            rdata <= dev_acc_gain;
        else if (addr == `ADDR_OP_CURRENT)
            rdata <= op_current;
        else if (addr == `ADDR_STOP_CURRENT)
            rdata <= stop_current;
        else if (addr == `ADDR_STATUS)
            rdata <= status_word;
        else if (addr == `ADDR_CUR_OUT)
            rdata <= current_cmd;
        else
            rdata <= 16'h0000;
    end

endmodule // motor_current_control_tuning

`default_nettype wire

//--- hdl/motor_tuning_defines.vh
`ifndef MOTOR_TUNING_DEFINES_VH
`define MOTOR_TUNING_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_RES_FREQ        8'h00
`define ADDR_RES_GAIN        8'h04
`define ADDR_CUTBACK_EN      8'h08
`define ADDR_CUTBACK_DELAY   8'h0c
`define ADDR_CUR_MODE        8'h10
`define ADDR_SVE_RATIO       8'h14
`define ADDR_POS_GAIN        8'h18
`define ADDR_SPD_GAIN        8'h1c
`define ADDR_SPD_INTEG       8'h20
`define ADDR_RAMP_UP         8'h24
`define ADDR_RAMP_DOWN       8'h28
`define ADDR_DEV_ACC_GAIN    8'h2c
`define ADDR_OP_CURRENT      8'h30
`define ADDR_STOP_CURRENT    8'h34
`define ADDR_STATUS          8'h38
`define ADDR_CUR_OUT         8'h3c

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define RES_FREQ_MIN         16'h0064
`define RES_FREQ_MAX         16'h07d0
`define RES_FREQ_RST         16'h03e8
`define RES_GAIN_MIN         16'hfe0c
`define RES_GAIN_MAX         16'h01f4
`define RES_GAIN_RST         16'h0000
`define CUTBACK_EN_RST       1'b1
`define CUTBACK_DELAY_MAX    16'h03e8
`define CUTBACK_DELAY_RST    16'h0064
`define CUR_MODE_INPUT       2'h0
`define CUR_MODE_CLOSED      2'h1
`define CUR_MODE_SERVO       2'h2
`define CUR_MODE_RST         2'h0
`define SVE_RATIO_MAX        16'h03e8
`define SVE_RATIO_RST        16'h03e8
`define POS_GAIN_MIN         16'h0001
`define POS_GAIN_MAX         16'h0032
`define POS_GAIN_RST         16'h000a
`define SPD_GAIN_MIN         16'h000a
`define SPD_GAIN_MAX         16'h00c8
`define SPD_GAIN_RST         16'h00b4
`define SPD_INTEG_MIN        16'h0064
`define SPD_INTEG_MAX        16'h07d0
`define SPD_INTEG_RST        16'h03e8
`define RAMP_MAX             16'h0064
`define RAMP_RST             16'h0000
`define DEV_ACC_MAX          16'h01f4
`define DEV_ACC_RST          16'h002d
`define CURRENT_FULL         16'h03e8
`define OP_CURRENT_RST       16'h03e8
`define STOP_CURRENT_RST     16'h01f4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ               100000000
`define MS_NS                1000000
`define CLK_NS               10
`define CYCLES_PER_MS        (`MS_NS / `CLK_NS)

`endif

//--- verif/motor_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Motor and feedback pins
// ----------------------------------------
module motor_far_side (
    // Clock and requests
    input wire logic  clk,
    input wire logic  moving,
    input wire logic  servo_req,
    // Pins toward the driver
    output var logic  motion_active,
    output var logic  current_mode_select_input
);
    initial
    begin
        motion_active             = 1'b1;
        current_mode_select_input = 1'b0;
    end
    // Pins change only after an edge, as a real encoder board would
    always @(posedge clk)
    begin
        motion_active             <= moving;
        current_mode_select_input <= servo_req;
    end
endmodule // motor_far_side
`default_nettype wire

//--- verif/motor_tuning_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Tuning checker
// ----------------------------------------
module motor_tuning_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    // Pins and outputs
    input wire logic        current_mode_select_input,
    input wire logic        servo_emulation_mode,
    input wire logic        closed_loop_current_mode,
    input wire logic [15:0] servo_current,
    input wire logic [15:0] res_freq,
    input wire logic [15:0] res_gain,
    input wire logic [15:0] pos_gain,
    input wire logic [15:0] spd_gain,
    input wire logic [15:0] spd_integ,
    input wire logic [15:0] dev_acc_gain
);
    logic [1:0] mode_code;
    logic       ratio_zero;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow of mode and ratio writes, since registers are not visible here
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_code  <= 2'h0;
            ratio_zero <= 1'b0;
        end
        else if (wr && addr == 8'h10)
            mode_code <= (wdata > 16'h0002) ? 2'h2 : wdata[1:0];
        else if (wr && addr == 8'h14)
            ratio_zero <= (wdata == 16'h0000);
    end
    property p_mode_excl;
        servo_emulation_mode != closed_loop_current_mode;
    endproperty
    a_mode_excl: assert property (p_mode_excl)
        else $error("mode outputs not complementary");
    property p_freq_range;
        res_freq >= 16'h0064 && res_freq <= 16'h07d0;
    endproperty
    a_freq_range: assert property (p_freq_range)
        else $error("resonance frequency out of range");
    property p_gain_range;
        $signed(res_gain) >= -16'sd500 && $signed(res_gain) <= 16'sd500;
    endproperty
    a_gain_range: assert property (p_gain_range)
        else $error("resonance gain out of range");
    property p_dev_range;
        dev_acc_gain <= 16'h01f4;
    endproperty
    a_dev_range: assert property (p_dev_range)
        else $error("deviation gain out of range");
    property p_servo_off;
        closed_loop_current_mode[*3] |-> pos_gain == 16'h0000 && spd_gain == 16'h0000
            && servo_current == 16'h0000;
    endproperty
    a_servo_off: assert property (p_servo_off)
        else $error("servo settings applied in closed-loop mode");
    property p_servo_gains;
        servo_emulation_mode[*3] |-> pos_gain >= 16'h0001 && pos_gain <= 16'h0032
            && spd_gain >= 16'h000a && spd_gain <= 16'h00c8
            && spd_integ >= 16'h0064 && spd_integ <= 16'h07d0;
    endproperty
    a_servo_gains: assert property (p_servo_gains)
        else $error("servo loop gains out of range");
    property p_forced_mode;
        (mode_code != 2'h0 && !ratio_zero && $stable(mode_code))[*3]
            |-> servo_emulation_mode == (mode_code == 2'h2);
    endproperty
    a_forced_mode: assert property (p_forced_mode)
        else $error("forced mode not applied");
    property p_pin_follow;
        (mode_code == 2'h0 && !ratio_zero && $stable(current_mode_select_input))[*4]
            |-> servo_emulation_mode == current_mode_select_input;
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("mode does not follow select pin");
    property p_ratio_zero;
        ratio_zero[*3] |-> closed_loop_current_mode;
    endproperty
    a_ratio_zero: assert property (p_ratio_zero)
        else $error("zero ratio did not force closed-loop mode");
endmodule // motor_tuning_chk

bind motor_current_control_tuning motor_tuning_chk u_chk (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .current_mode_select_input(current_mode_select_input),
    .servo_emulation_mode(servo_emulation_mode),
    .closed_loop_current_mode(closed_loop_current_mode),
    .servo_current(servo_current), .res_freq(res_freq), .res_gain(res_gain),
    .pos_gain(pos_gain), .spd_gain(spd_gain), .spd_integ(spd_integ),
    .dev_acc_gain(dev_acc_gain)
);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "motor_tuning_defines.vh"
module testbench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        moving = 1'b1;
    logic        servo_req = 1'b0;
    logic        motion_active, sel_pin, servo_m, closed_m;
    logic [15:0] rdata, current_cmd, servo_current, res_freq, res_gain;
    logic [15:0] pos_gain, spd_gain, spd_integ, dev_acc_gain;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [7:0]  def_a [14] = '{`ADDR_RES_FREQ, `ADDR_RES_GAIN, `ADDR_CUTBACK_EN,
        `ADDR_CUTBACK_DELAY, `ADDR_CUR_MODE, `ADDR_SVE_RATIO, `ADDR_POS_GAIN,
        `ADDR_SPD_GAIN, `ADDR_SPD_INTEG, `ADDR_RAMP_UP, `ADDR_RAMP_DOWN,
        `ADDR_DEV_ACC_GAIN, `ADDR_OP_CURRENT, `ADDR_STOP_CURRENT};
    logic [15:0] def_v [14] = '{16'h03e8, 16'h0000, 16'h0001, 16'h0064, 16'h0000,
        16'h03e8, 16'h000a, 16'h00b4, 16'h03e8, 16'h0000, 16'h0000, 16'h002d,
        16'h03e8, 16'h01f4};

    initial forever #5 clk = ~clk;

    motor_current_control_tuning u_dut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .motion_active(motion_active), .current_mode_select_input(sel_pin),
        .current_cmd(current_cmd), .servo_emulation_mode(servo_m),
        .closed_loop_current_mode(closed_m), .servo_current(servo_current),
        .res_freq(res_freq), .res_gain(res_gain), .pos_gain(pos_gain),
        .spd_gain(spd_gain), .spd_integ(spd_integ), .dev_acc_gain(dev_acc_gain)
    );
    motor_far_side u_far (
        .clk(clk), .moving(moving), .servo_req(servo_req),
        .motion_active(motion_active), .current_mode_select_input(sel_pin)
    );

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_cmd(input logic [15:0] exp, input int lim);
        int n;
        n = 0;
        while (current_cmd !== exp && n < lim)
        begin
            settle(1);
            n++;
        end
        chk("current_cmd", current_cmd, exp);
    endtask
    task set_moving(input logic m);
        @(posedge clk);
        moving <= m;
    endtask

    task t_defaults;
        for (int i = 0; i < 14; i++)
            rd_chk("default", def_a[i], def_v[i]);
        rd_chk("unmapped", 8'h40, 16'h0000);
        $display("test defaults done");
    endtask
    task t_limits;
        reg_wr(`ADDR_RES_FREQ, 16'h0032);
        rd_chk("freq_low", `ADDR_RES_FREQ, 16'h0064);
        chk("res_freq", res_freq, 16'h0064);
        reg_wr(`ADDR_RES_FREQ, 16'h07cf);
        rd_chk("freq_in", `ADDR_RES_FREQ, 16'h07cf);
        reg_wr(`ADDR_RES_FREQ, 16'h0bb8);
        rd_chk("freq_high", `ADDR_RES_FREQ, 16'h07d0);
        reg_wr(`ADDR_RES_GAIN, 16'hfda8);
        rd_chk("gain_neg", `ADDR_RES_GAIN, 16'hfe0c);
        reg_wr(`ADDR_RES_GAIN, 16'h0258);
        settle(1);
        chk("res_gain", res_gain, 16'h01f4);
        reg_wr(`ADDR_DEV_ACC_GAIN, 16'h0258);
        settle(1);
        chk("dev_acc_gain", dev_acc_gain, 16'h01f4);
        $display("test limits done");
    endtask
    task t_mode;
        settle(6);
        chk("closed_pin_off", 16'(closed_m), 16'h0001);
        @(posedge clk) servo_req <= 1'b1;
        settle(8);
        chk("servo_pin_on", 16'(servo_m), 16'h0001);
        chk("pos_gain", pos_gain, 16'h000a);
        chk("spd_gain", spd_gain, 16'h00b4);
        chk("spd_integ", spd_integ, 16'h03e8);
        chk("servo_full", servo_current, 16'h03e8);
        reg_wr(`ADDR_SVE_RATIO, 16'h01f4);
        settle(4);
        chk("servo_half", servo_current, 16'h01f4);
        reg_wr(`ADDR_SVE_RATIO, 16'h0000);
        settle(4);
        chk("closed_ratio0", 16'(closed_m), 16'h0001);
        chk("pos_gain_off", pos_gain, 16'h0000);
        reg_wr(`ADDR_SVE_RATIO, 16'h03e8);
        reg_wr(`ADDR_CUR_MODE, 16'h0001);
        settle(4);
        chk("closed_forced", 16'(closed_m), 16'h0001);
        @(posedge clk) servo_req <= 1'b0;
        reg_wr(`ADDR_CUR_MODE, 16'h0002);
        settle(8);
        chk("servo_forced", 16'(servo_m), 16'h0001);
        reg_wr(`ADDR_CUR_MODE, 16'h0003);
        rd_chk("mode_sat", `ADDR_CUR_MODE, 16'h0002);
        reg_wr(`ADDR_CUR_MODE, 16'h0000);
        settle(4);
        chk("closed_back", 16'(closed_m), 16'h0001);
        $display("test mode done");
    endtask
    task t_cutback;
        reg_wr(`ADDR_CUTBACK_DELAY, 16'h0000);
        set_moving(1'b0);
        wait_cmd(16'h01f4, 20);
        rd_chk("status_cut", `ADDR_STATUS, 16'h0004);
        set_moving(1'b1);
        wait_cmd(16'h03e8, 20);
        reg_wr(`ADDR_RAMP_DOWN, 16'h0064);
        set_moving(1'b0);
        wait_cmd(16'h01f4, 20);
        set_moving(1'b1);
        wait_cmd(16'h03e8, 20);
        reg_wr(`ADDR_RAMP_DOWN, 16'h0000);
        reg_wr(`ADDR_CUTBACK_DELAY, 16'h0001);
        set_moving(1'b0);
        settle(50);
        chk("delay_hold", current_cmd, 16'h03e8);
        reg_wr(`ADDR_CUTBACK_EN, 16'h0000);
        set_moving(1'b0);
        settle(30);
        chk("no_cutback", current_cmd, 16'h03e8);
        set_moving(1'b1);
        reg_wr(`ADDR_CUTBACK_EN, 16'h0001);
        $display("test cutback done");
    endtask
    task t_ramp;
        reg_wr(`ADDR_RAMP_DOWN, 16'h0001);
        reg_wr(`ADDR_OP_CURRENT, 16'h03de);
        settle(20);
        chk("ramp_down_mid", 16'(current_cmd > 16'h03de), 16'h0001);
        wait_cmd(16'h03de, 1200);
        reg_wr(`ADDR_RAMP_UP, 16'h0001);
        reg_wr(`ADDR_OP_CURRENT, 16'h03e8);
        settle(20);
        chk("ramp_up_mid", 16'(current_cmd < 16'h03e8), 16'h0001);
        wait_cmd(16'h03e8, 1200);
        reg_wr(`ADDR_RAMP_UP, 16'h0000);
        reg_wr(`ADDR_RAMP_DOWN, 16'h0000);
        reg_wr(`ADDR_OP_CURRENT, 16'h0320);
        wait_cmd(16'h0320, 3);
        reg_wr(`ADDR_OP_CURRENT, 16'h03e8);
        wait_cmd(16'h03e8, 3);
        $display("test ramp done");
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_defaults;
        t_limits;
        t_mode;
        t_cutback;
        t_ramp;
        wrap_up;
    end
    // Whole run is a few thousand cycles; this span is far beyond it
    initial
    begin
        #500000;
        error_cnt++;
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
